//--- logic/pimb_bridge.v
// One bridge unit: input mirroring, reader READER_LED_LINE, range test, indicators,
// heartbeat and relay fallback. Assumes a radio modem outside that sends
// frames on request and delivers received frames with their strength.
//
// Function
// - Remote drives relays 1 and 2 from controller relay inputs 1, 2.
// - Controller drives relays 3 and 4 from remote relay inputs 3, 4.
// - Input low means active; matching relay active while it stays low.
// - Reader READER_LED_LINE idles high, low exactly while its source is active.
// - Reader READER_LED_LINE source: relay 1 default, relay 2, or controller READER_LED_LINE input.
// - Remote auxiliary input low drives controller auxiliary output low.
// - Short button press starts a range test transmission and evaluation.
// - Range result as six-READER_LED_LINE bar: one lit minimum, six maximum.
// - Receive indicator pulses briefly once per received transmission.
// - Transmit indicator pulses briefly on every send request, replies and status checks included.
// - Strength LEDs have enable and persistence, default on, one second.
// - Relays take fallback value after heartbeat-multiple link-loss time.
// - Five-second continuous button press grants configuration access.
// - Heartbeat timer restarts on success; expiry sends a status check.
// - Fallback disabled by default; relays then hold state on link loss.
`timescale 1ns/1ns
`include "pimb_consts.vh"
module pimb_bridge #(
  parameter MS_CYCLES = `PIMB_CLK_HZ / `PIMB_MS_PER_S
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        relay1_ctrl_input_n,
  input  wire        relay2_ctrl_input_n,
  input  wire        relay3_ctrl_input_n,
  input  wire        relay4_ctrl_input_n,
  input  wire        aux_in_n,
  input  wire        reader_led_line_in_n,
  input  wire        test_button_n,
  input  wire        rx_valid,
  input  wire [6:0]  rx_payload,
  input  wire [7:0]  rx_rssi,
  input  wire        tx_busy,
  input  wire        tx_done,
  output reg         tx_req,
  output reg  [6:0]  tx_payload,
  output reg  [3:0]  relay_out,
  output reg         reader_led_line,
  output reg         aux_out,
  output reg  [5:0]  strength_led,
  output reg         receive_indicator,
  output reg         transmit_indicator,
  output reg         config_grant,
  output reg         status_check
);

  reg  [8:0]  ctrl;
  reg  [15:0] persist_ms;
  reg  [15:0] hbeat_s;
  reg  [7:0]  fb_mult;
  reg  [14:0] pre;
  reg         ms_tick;
  reg  [9:0]  ms_in_s;
  reg         s_tick;
  wire [6:0]  raw_n;
  wire [6:0]  db_n;
  wire        role_remote;
  wire [6:0]  act;

  assign raw_n = {test_button_n, reader_led_line_in_n, aux_in_n,
                  relay4_ctrl_input_n, relay3_ctrl_input_n,
                  relay2_ctrl_input_n, relay1_ctrl_input_n};
  assign role_remote = ctrl[`PIMB_F_ROLE];
  assign act = ~db_n;

  // Millisecond and second ticks keep all long timers small
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre     <= 15'h0000;
      ms_tick <= 1'b0;
      ms_in_s <= 10'h000;
      s_tick  <= 1'b0;
    end else begin
      ms_tick <= (pre == MS_CYCLES[14:0] - 15'h0001);
      pre     <= (pre == MS_CYCLES[14:0] - 15'h0001) ? 15'h0000
                                                      : pre + 15'h0001;
      s_tick  <= 1'b0;
      if (ms_tick) begin
        if (ms_in_s == `PIMB_MS_PER_S - 1) begin
          ms_in_s <= 10'h000;
          s_tick  <= 1'b1;
        end else begin
          ms_in_s <= ms_in_s + 10'h001;
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_deb
      reg       s1;
      reg       s2;
      reg       d;
      reg [3:0] c;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          d  <= 1'b1;
          c  <= 4'h0;
        end else begin
          s1 <= raw_n[gi];
          s2 <= s1;
          if (s2 == d) begin
            c <= 4'h0;
          end else if (ms_tick) begin
            if (c == `PIMB_DEB_MS - 4'h1) begin
              d <= s2;
              c <= 4'h0;
            end else begin
              c <= c + 4'h1;
            end
          end
        end
      end
      assign db_n[gi] = d;
    end
  endgenerate

  // Local state sent to the partner: relays 1,2 and READER_LED_LINE, or relays 3,4, aux
  wire [2:0] local_bits;
  assign local_bits = role_remote ? {act[4], act[3], act[2]}
                                  : {act[5], act[1], act[0]};

  reg  [2:0]  peer_bits;
  reg  [2:0]  sent_bits;
  reg         range_pend;
  reg         range_wait;
  reg         reply_pend;
  reg         check_pend;
  reg  [12:0] btn_ms;
  reg         btn_prev;
  reg  [15:0] hb_cnt;
  reg  [7:0]  missed;
  reg         link_lost;
  reg  [15:0] bar_ms;
  reg  [7:0]  rx_ms;
  reg  [7:0]  tx_ms;
  reg         granted;
  wire        btn_rel;
  wire        range_start;
  wire        rx_range;
  wire        send_ok;
  wire [1:0]  send_kind;
  wire [5:0]  bar;
  wire        fb_apply;
  wire        src_on;
  wire [1:0]  rel_mirror;
  wire [1:0]  rel_fb;

  assign btn_rel     = btn_prev & ~act[6];
  assign range_start = btn_rel & (btn_ms < `PIMB_SHORT_MS);
  assign rx_range    = rx_valid & (rx_payload[6:5] == `PIMB_K_RANGE);
  assign send_ok     = ~tx_busy & ~tx_req;
  assign send_kind   = range_pend ? `PIMB_K_RANGE :
                       reply_pend ? `PIMB_K_REPLY :
                       check_pend ? `PIMB_K_CHECK : `PIMB_K_STATE;

  // Bar graph, first READER_LED_LINE always lit
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_bar
      assign bar[gi] = ({1'b0, rx_rssi} >= gi * `PIMB_RSSI_STEP);
    end
  endgenerate

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_prev     <= 1'b0;
      btn_ms       <= 13'h0000;
      granted      <= 1'b0;
      config_grant <= 1'b0;
    end else begin
      btn_prev     <= act[6];
      config_grant <= 1'b0;
      if (!act[6]) begin
        btn_ms  <= 13'h0000;
        granted <= 1'b0;
      end else if (ms_tick && btn_ms != `PIMB_GRANT_MS) begin
        btn_ms <= btn_ms + 13'h0001;
      end
      // Five seconds held, one grant per hold
      if (act[6] && btn_ms == `PIMB_GRANT_MS && !granted) begin
        granted      <= 1'b1;
        config_grant <= 1'b1;
      end
    end
  end

  // Requests to the modem; a new request beats the clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_req     <= 1'b0;
      tx_payload <= 7'h00;
      sent_bits  <= 3'h0;
      range_pend <= 1'b0;
      reply_pend <= 1'b0;
      check_pend <= 1'b0;
    end else begin
      tx_req <= 1'b0;
      if (send_ok && (range_pend || reply_pend || check_pend ||
                      local_bits != sent_bits)) begin
        tx_req     <= 1'b1;
        tx_payload <= {send_kind, 2'h0, local_bits};
        sent_bits  <= local_bits;
        if (range_pend) begin
          range_pend <= 1'b0;
        end else if (reply_pend) begin
          reply_pend <= 1'b0;
        end else begin
          check_pend <= 1'b0;
        end
      end
      if (range_start) begin
        range_pend <= 1'b1;
      end
      if (rx_range) begin
        reply_pend <= 1'b1;
      end
      // Expiry asks for a status check
      if (s_tick && hb_cnt + 16'h0001 >= hbeat_s) begin
        check_pend <= 1'b1;
      end
    end
  end

  // Heartbeat, link loss and mirrored peer state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hb_cnt       <= 16'h0000;
      missed       <= 8'h00;
      link_lost    <= 1'b0;
      peer_bits    <= 3'h0;
      status_check <= 1'b0;
    end else begin
      status_check <= 1'b0;
      if (rx_valid) begin
        peer_bits <= rx_payload[2:0];
      end
      if (tx_done || rx_valid) begin
        hb_cnt    <= 16'h0000;
        missed    <= 8'h00;
        link_lost <= 1'b0;
      end else if (s_tick) begin
        if (hb_cnt + 16'h0001 >= hbeat_s) begin
          hb_cnt       <= 16'h0000;
          status_check <= 1'b1;
          if (missed != 8'hFF) begin
            missed <= missed + 8'h01;
          end
          // Lost after a multiple of heartbeats
          if (missed + 8'h01 >= fb_mult) begin
            link_lost <= 1'b1;
          end
        end else begin
          hb_cnt <= hb_cnt + 16'h0001;
        end
      end
    end
  end

  // Without fallback the last state simply stays
  assign fb_apply   = link_lost & ctrl[`PIMB_F_FBEN];
  assign rel_fb     = role_remote ? ctrl[`PIMB_F_FBV_LO+1:`PIMB_F_FBV_LO]
                                  : ctrl[`PIMB_F_FBV_HI:`PIMB_F_FBV_HI-1];
  assign rel_mirror = fb_apply ? rel_fb : peer_bits[1:0];
  assign src_on     = (ctrl[`PIMB_F_SRC_HI:`PIMB_F_SRC_LO] == `PIMB_SRC_R2)
                      ? rel_mirror[1]
                      : (ctrl[`PIMB_F_SRC_HI:`PIMB_F_SRC_LO] == `PIMB_SRC_LED)
                      ? peer_bits[2] : rel_mirror[0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_out       <= 4'h0;
      reader_led_line <= 1'b1;
      aux_out         <= 1'b1;
    end else if (role_remote) begin
      // Relays 1 and 2 follow the controller
      relay_out       <= {2'b00, rel_mirror};
      reader_led_line <= ~src_on;
      aux_out         <= 1'b1;
    end else begin
      // Relays 3 and 4 follow the remote
      relay_out       <= {rel_mirror, 2'b00};
      reader_led_line <= 1'b1;
      aux_out         <= ~peer_bits[2];
    end
  end

  // Indicators and strength bar
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ms              <= 8'h00;
      tx_ms              <= 8'h00;
      bar_ms             <= 16'h0000;
      range_wait         <= 1'b0;
      strength_led       <= 6'h00;
      receive_indicator  <= 1'b0;
      transmit_indicator <= 1'b0;
    end else begin
      if (rx_valid) begin
        rx_ms <= `PIMB_IND_MS;
      end else if (ms_tick && rx_ms != 8'h00) begin
        rx_ms <= rx_ms - 8'h01;
      end
      if (tx_req) begin
        tx_ms <= `PIMB_IND_MS;
      end else if (ms_tick && tx_ms != 8'h00) begin
        tx_ms <= tx_ms - 8'h01;
      end
      receive_indicator  <= rx_valid | (rx_ms != 8'h00);
      transmit_indicator <= tx_req | (tx_ms != 8'h00);
      if (range_start) begin
        range_wait <= 1'b1;
      end else if (rx_valid && rx_payload[6:5] == `PIMB_K_REPLY) begin
        range_wait <= 1'b0;
      end
      if (range_wait && rx_valid && rx_payload[6:5] == `PIMB_K_REPLY &&
          ctrl[`PIMB_F_SEN]) begin
        strength_led <= bar;
        bar_ms       <= persist_ms;
      end else if (bar_ms == 16'h0000 || !ctrl[`PIMB_F_SEN]) begin
        strength_led <= 6'h00;
        bar_ms       <= 16'h0000;
      end else if (ms_tick) begin
        bar_ms <= bar_ms - 16'h0001;
      end
    end
  end

  // APB slave: answer readied in setup, so access ends in its first cycle
  wire       wr_en;
  reg        hit;
  reg [31:0] rd_val;

  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always @* begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    if (paddr == `PIMB_A_CTRL) begin
      rd_val = {23'h000000, ctrl};
    end else if (paddr == `PIMB_A_PERSIST) begin
      rd_val = {16'h0000, persist_ms};
    end else if (paddr == `PIMB_A_HBEAT) begin
      rd_val = {16'h0000, hbeat_s};
    end else if (paddr == `PIMB_A_FBMULT) begin
      rd_val = {24'h000000, fb_mult};
    end else if (paddr == `PIMB_A_STATUS) begin
      rd_val = {missed, 2'b00, link_lost, granted, strength_led,
                relay_out, 3'b000, act};
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h00000000;
      ctrl       <= `PIMB_CTRL_RST;
      persist_ms <= `PIMB_PERSIST_RST;
      hbeat_s    <= `PIMB_HBEAT_RST;
      fb_mult    <= `PIMB_FBMULT_RST;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h00000000;
      if (wr_en && paddr == `PIMB_A_CTRL) begin
        ctrl <= pwdata[8:0];
      end else if (wr_en && paddr == `PIMB_A_PERSIST) begin
        persist_ms <= pwdata[15:0];
      end else if (wr_en && paddr == `PIMB_A_HBEAT) begin
        hbeat_s <= pwdata[15:0];
      end else if (wr_en && paddr == `PIMB_A_FBMULT) begin
        fb_mult <= pwdata[7:0];
      end
    end
  end

endmodule // pimb_bridge

//--- logic/pimb_consts.vh
// Constants of the paired I/O mirror bridge: map, fields, resets, timing.
// Assumes a 20 MHz clock and a 32-bit APB register port.
`ifndef PIMB_CONSTS_VH
`define PIMB_CONSTS_VH
`define PIMB_CLK_HZ      20000000
`define PIMB_MS_PER_S    1000
`define PIMB_ADDR_W      12
`define PIMB_A_CTRL      12'h000
`define PIMB_A_PERSIST   12'h004
`define PIMB_A_HBEAT     12'h008
`define PIMB_A_FBMULT    12'h00C
`define PIMB_A_STATUS    12'h010
`define PIMB_CTRL_RST    9'h009
`define PIMB_PERSIST_RST 16'h03E8
`define PIMB_HBEAT_RST   16'h0E10
`define PIMB_FBMULT_RST  8'h01
`define PIMB_F_ROLE      0
`define PIMB_F_SRC_LO    1
`define PIMB_F_SRC_HI    2
`define PIMB_F_SEN       3
`define PIMB_F_FBEN      4
`define PIMB_F_FBV_LO    5
`define PIMB_F_FBV_HI    8
`define PIMB_SRC_R1      2'h0
`define PIMB_SRC_R2      2'h1
`define PIMB_SRC_LED     2'h2
`define PIMB_K_STATE     2'h0
`define PIMB_K_RANGE     2'h1
`define PIMB_K_REPLY     2'h2
`define PIMB_K_CHECK     2'h3
`define PIMB_DEB_MS      4'hA
`define PIMB_IND_MS      8'h32
`define PIMB_SHORT_MS    13'h03E8
`define PIMB_GRANT_MS    13'h1388
`define PIMB_RSSI_STEP   8'h2B
`endif

//--- verif/pimb_chk_asserts.sv
// Checker: handshake, pulse and timing relations at the bridge ports.
// Assumes bind onto pimb_bridge with MS_CYCLES handed on.
`timescale 1ns/1ns
module pimb_chk #(
  parameter int MS_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       test_button_n,
  input wire logic       rx_valid,
  input wire logic       tx_busy,
  input wire logic       tx_req,
  input wire logic [5:0] strength_led,
  input wire logic       receive_indicator,
  input wire logic       config_grant,
  input wire logic       status_check
);
  localparam int GRANT_CYC = 5000 * MS_CYCLES;
  int btn_run;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Raw press length; saturates so it never wraps
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_run <= 0;
    end else if (test_button_n) begin
      btn_run <= 0;
    end else if (btn_run < GRANT_CYC) begin
      btn_run <= btn_run + 1;
    end
  end
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SLVERR_QUAL: assert property (pslverr |-> pready && psel)
    else $error("pslverr outside access");
  AST_RX_IND: assert property (rx_valid |-> ##[1:2] receive_indicator)
    else $error("receive indicator missing");
  AST_TX_GAP: assert property (tx_req |=> !tx_req)
    else $error("send requests too close");
  AST_TX_IDLE: assert property (tx_req |-> !$past(tx_busy))
    else $error("send request while modem busy");
  AST_BAR: assert property (strength_led inside {6'h00, 6'h01, 6'h03,
    6'h07, 6'h0F, 6'h1F, 6'h3F}) else $error("strength bar has a gap");
  AST_GRANT: assert property (config_grant |-> btn_run >= GRANT_CYC)
    else $error("grant before five second press");
  AST_CHECK_ONE: assert property (status_check |=> !status_check)
    else $error("status check pulse too long");
  COV_ERR: cover property (pslverr);
  COV_GRANT: cover property (config_grant);
  COV_CHECK: cover property (status_check);
  COV_FULL: cover property (strength_led == 6'h3F);
endmodule // pimb_chk

bind pimb_bridge pimb_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .test_button_n(test_button_n),
  .rx_valid(rx_valid), .tx_busy(tx_busy), .tx_req(tx_req),
  .strength_led(strength_led), .receive_indicator(receive_indicator),
  .config_grant(config_grant), .status_check(status_check));

//--- verif/pimb_peer.sv
// Paired unit model: modem answer to sends, frames sent on command.
// Assumes the bench calls send() and may set mute to drop completions.
`timescale 1ns/1ns
module pimb_peer #(
  parameter int DLY = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_req,
  input  wire logic [6:0] tx_payload,
  output logic            tx_busy,
  output logic            tx_done,
  output logic            rx_valid,
  output logic [6:0]      rx_payload,
  output logic [7:0]      rx_rssi
);
  logic [6:0] last_tx;
  int         n_tx;
  int         cnt;
  logic       mute = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_payload = 7'h00;
    rx_rssi = 8'h00;
  end
  // Busy for DLY+1 cycles; mute models a lost link
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      cnt <= 0;
      n_tx <= 0;
      last_tx <= 7'h00;
    end else begin
      tx_done <= 1'b0;
      if (tx_req) begin
        tx_busy <= 1'b1;
        cnt <= DLY;
        last_tx <= tx_payload;
        n_tx <= n_tx + 1;
      end else if (tx_busy && cnt == 0) begin
        tx_busy <= 1'b0;
        tx_done <= !mute;
      end else if (tx_busy) begin
        cnt <= cnt - 1;
      end
    end
  end
  task automatic send(input logic [1:0] k, input logic [2:0] b,
                      input logic [7:0] r);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_payload <= {k, 2'b00, b};
    rx_rssi <= r;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_payload <= ~{k, 2'b00, b};
    rx_rssi <= ~r;
  endtask
endmodule // pimb_peer

//--- verif/pimb_bridge_tb.sv
// Bench: APB and pin stimulus on one unit, peer model on the radio side.
// Assumes MS_CYCLES of 4 so seconds stay short.
`timescale 1ns/1ns
`include "pimb_consts.vh"
module pimb_bridge_tb;
  localparam int MS = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  pins = 7'h7F;
  wire  [31:0] prdata;
  wire         pready, pslverr, rx_valid, tx_busy, tx_done, tx_req;
  wire  [6:0]  rx_payload, tx_payload;
  wire  [7:0]  rx_rssi;
  wire  [3:0]  relay_out;
  wire  [5:0]  strength_led;
  wire         reader_led_line, aux_out, receive_indicator;
  wire         transmit_indicator, config_grant, status_check;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n;
  always #25 clk = ~clk;
  pimb_bridge #(.MS_CYCLES(MS)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relay1_ctrl_input_n(pins[0]), .relay2_ctrl_input_n(pins[1]),
    .relay3_ctrl_input_n(pins[2]), .relay4_ctrl_input_n(pins[3]),
    .aux_in_n(pins[4]), .reader_led_line_in_n(pins[5]),
    .test_button_n(pins[6]), .rx_valid(rx_valid), .rx_payload(rx_payload),
    .rx_rssi(rx_rssi), .tx_busy(tx_busy), .tx_done(tx_done),
    .tx_req(tx_req), .tx_payload(tx_payload), .relay_out(relay_out),
    .reader_led_line(reader_led_line), .aux_out(aux_out),
    .strength_led(strength_led), .receive_indicator(receive_indicator),
    .transmit_indicator(transmit_indicator), .config_grant(config_grant),
    .status_check(status_check));
  pimb_peer peer_u (.clk(clk), .rst(rst), .tx_req(tx_req),
    .tx_payload(tx_payload), .tx_busy(tx_busy), .tx_done(tx_done),
    .rx_valid(rx_valid), .rx_payload(rx_payload), .rx_rssi(rx_rssi));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q[32], e[32]);
    chk(q[31:0], e[31:0]);
  endtask
  task automatic range(input logic [31:0] c, input logic [7:0] r,
                       input logic [5:0] e);
    wreg(`PIMB_A_CTRL, c);
    pins[6] <= 1'b0;
    cyc(100);
    pins[6] <= 1'b1;
    cyc(60);
    chk(peer_u.last_tx[6:5], `PIMB_K_RANGE);
    peer_u.send(`PIMB_K_REPLY, 3'h0, r);
    cyc(3800);
    chk(strength_led, e);
    cyc(300);
    chk(strength_led, 6'h00);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Longest path is about 50000 cycles
  initial begin
    cyc(70000);
    bad_count++;
    wrap_up();
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    chk(reader_led_line, 1'b1);
    chk(aux_out, 1'b1);
    rchk(`PIMB_A_CTRL, 33'h009);
    rchk(`PIMB_A_PERSIST, 33'h3E8);
    rchk(`PIMB_A_HBEAT, 33'hE10);
    rchk(`PIMB_A_FBMULT, 33'h001);
    rchk(12'h014, 33'h1_0000_0000);
    for (int s = 0; s < 3; s++) begin
      wreg(`PIMB_A_CTRL, 32'h9 | (s << 1));
      peer_u.send(`PIMB_K_STATE, 3'b001 << s, 8'h10);
      cyc(3);
      chk(reader_led_line, 1'b0);
      chk(relay_out, {2'b00, 2'(3'b001 << s)});
      peer_u.send(`PIMB_K_STATE, ~(3'b001 << s), 8'h10);
      cyc(3);
      chk(reader_led_line, 1'b1);
    end
    pins[2] <= 1'b0;
    cyc(60);
    chk(peer_u.last_tx, 7'h01);
    chk(transmit_indicator, 1'b1);
    n = peer_u.n_tx;
    pins[3] <= 1'b0;
    cyc(5);
    pins[3] <= 1'b1;
    cyc(60);
    chk(peer_u.n_tx, n);
    pins[4] <= 1'b0;
    cyc(60);
    chk(peer_u.last_tx, 7'h05);
    rchk(`PIMB_A_STATUS, 33'h0C14);
    pins <= 7'h7F;
    cyc(60);
    wreg(`PIMB_A_CTRL, 32'h8);
    peer_u.send(`PIMB_K_STATE, 3'b111, 8'h10);
    cyc(3);
    chk(relay_out, 4'hC);
    chk(aux_out, 1'b0);
    peer_u.send(`PIMB_K_STATE, 3'b000, 8'h10);
    cyc(3);
    chk(relay_out, 4'h0);
    range(32'h08, 8'hFF, 6'h3F);
    range(32'h08, 8'h00, 6'h01);
    range(32'h00, 8'hFF, 6'h00);
    wreg(`PIMB_A_PERSIST, 32'h64);
    rchk(`PIMB_A_PERSIST, 33'h064);
    peer_u.send(`PIMB_K_STATE, 3'b000, 8'h10);
    cyc(3);
    chk(receive_indicator, 1'b1);
    chk(transmit_indicator, 1'b0);
    peer_u.send(`PIMB_K_RANGE, 3'h0, 8'h10);
    cyc(10);
    chk(peer_u.last_tx[6:5], `PIMB_K_REPLY);
    pins[6] <= 1'b0;
    n = 0;
    while (config_grant !== 1'b1 && n < 21000) begin
      cyc(1);
      n++;
    end
    chk(n >= 5000 * MS && n < 21000, 1'b1);
    pins[6] <= 1'b1;
    cyc(60);
    wreg(`PIMB_A_HBEAT, 32'h1);
    peer_u.send(`PIMB_K_STATE, 3'b011, 8'h10);
    n = 0;
    while (status_check !== 1'b1 && n < 4100) begin
      cyc(1);
      n++;
    end
    chk(n > 0 && n < 4100, 1'b1);
    cyc(10);
    chk(peer_u.last_tx[6:5], `PIMB_K_CHECK);
    chk(relay_out, 4'hC);
    peer_u.mute <= 1'b1;
    wreg(`PIMB_A_CTRL, 32'h98);
    cyc(12500);
    chk(relay_out, 4'h4);
    wrap_up();
  end
endmodule // pimb_bridge_tb
